// >>> src/dofs_defines.svh
// constants of the dual-output fault status block
`ifndef DOFS_DEFINES_SVH
`define DOFS_DEFINES_SVH

// ----------------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------------
// 7-bit device address, value arbitrary
`define DOFS_DEV_ADDR 7'h08
`define DOFS_BYTE_W 8
`define DOFS_BIT_LAST 3'h7
`define DOFS_RW_BIT 0
// control byte: bit 7 picks the register, bit 6 picks the channel
`define DOFS_CTL_REG_BIT 7
`define DOFS_CTL_CH_BIT 6
`define DOFS_CTL_ON_BIT 5
`define DOFS_CTL_TIMER_BIT 4
`define DOFS_CTL_CABLE_BIT 2

// ----------------------------------------------------------------------
// status register layouts
// ----------------------------------------------------------------------
`define DOFS_S1_OFF 0
`define DOFS_S1_OCP 2
`define DOFS_S1_PBAD 4
`define DOFS_S1_OTEMP 6
`define DOFS_S1_UVOLT 7
`define DOFS_S2_CABLE 0
`define DOFS_S2_TONE 2
`define DOFS_S2_UNUSED_W 4
`define DOFS_S1_RST 8'h33
`define DOFS_S2_RST 8'h00

// ----------------------------------------------------------------------
// condition input positions (synchronised as one vector)
// ----------------------------------------------------------------------
`define DOFS_COND_W 14
`define DOFS_C_OC 0
`define DOFS_C_OTEMP 2
`define DOFS_C_UVOLT 3
`define DOFS_C_B85 4
`define DOFS_C_W90 6
`define DOFS_C_A21 8
`define DOFS_C_B1995 10
`define DOFS_C_TONE 12

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DOFS_SYS_CLK_HZ 100000000
`define DOFS_OCP_TIME_MS 48
`define DOFS_MS_PER_S 1000
`define DOFS_OCP_CYCLES \
    (`DOFS_OCP_TIME_MS * (`DOFS_SYS_CLK_HZ / `DOFS_MS_PER_S))
`define DOFS_OCP_CNT_W 23

`endif

// >>> src/dofs_pkg.sv
// types shared by the fault status block
`include "dofs_defines.svh"

package dofs_pkg;

    // ------------------------------------------------------------------
    // link-side transfer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DOFS_IDLE = 3'b000,
        DOFS_ADDR = 3'b001,
        DOFS_ADDR_ACK = 3'b010,
        DOFS_WDATA = 3'b011,
        DOFS_WACK = 3'b100,
        DOFS_RDATA = 3'b101,
        DOFS_RACK = 3'b110
    } dofs_link_st_t;

    // ------------------------------------------------------------------
    // link state sampled on the rising serial clock edge
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rst_meta;
        logic rst;
        logic sda_rise;
        logic [`DOFS_BYTE_W-1:0] rx;
        logic rd_tgl;
    } dofs_rise_t;

    // ------------------------------------------------------------------
    // link state updated on the falling serial clock edge
    // ------------------------------------------------------------------
    typedef struct packed {
        dofs_link_st_t st;
        logic [2:0] cnt;
        logic [`DOFS_BYTE_W-1:0] tx;
        logic sel_two;
        logic is_read;
        logic sda_oe;
        logic [`DOFS_BYTE_W-1:0] wr_data;
        logic wr_tgl;
        logic busy;
    } dofs_fall_t;

    // ------------------------------------------------------------------
    // system clock state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`DOFS_COND_W-1:0] cond_meta;
        logic [`DOFS_COND_W-1:0] cond;
        logic [2:0] wr_sync;
        logic [2:0] rd_sync;
        logic [1:0] busy_sync;
        logic [1:0] on;
        logic [1:0] timer_on;
        logic [1:0] cable_test;
        logic [1:0] out_off;
        logic [1:0] ocp;
        logic [1:0] power_bad;
        logic [1:0] cable_open;
        logic [1:0] tone;
        logic overtemp;
        logic undervolt;
        logic [1:0][`DOFS_OCP_CNT_W-1:0] oc_cnt;
        logic [`DOFS_BYTE_W-1:0] stat_one;
        logic [`DOFS_BYTE_W-1:0] stat_two;
    } dofs_sys_t;

endpackage : dofs_pkg

// >>> src/dofs_status.sv
// fault status registers with their serial read/write link
//
// Summary of operation
// - latched faults hold until read and fault gone
// - output off sets disabled flag until re-enabled
// - disabled flags set at reset, cleared by write
// - disabled flag raises no interrupt request
// - multi-byte read alternates register one and two
// - each new read starts with register one
// - fault-free enabled channels read all zeros
// - register one layout: off, ocp, pbad, temp, uv
// - register two layout: cable, tone, four unused
// - timed overcurrent past 48 ms disables output
// - ninth read clock rise updates, clears overcurrent
// - untimed overcurrent flag follows the condition live
// - power bad sets below 85%, clears within 90%
// - power bad reads one while output disabled
// - overtemperature disables both, latches, read clears
// - undervoltage disables both until enables rewritten
// - undervoltage flag sampled at ninth read rise
// - cable flag sets above 21 V, clears 19.95 V
// - cable flag clears when test off or connected
// - tone flag follows tone presence, non-latched
`include "dofs_defines.svh"

module dofs_status #(
    parameter int unsigned OCP_CYCLES = `DOFS_OCP_CYCLES
) (
    // system clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    // serial link
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE,
    // per-channel conditions from the analog side
    input wire logic [1:0] I_OVERCURRENT,
    input wire logic [1:0] I_BELOW_85PCT,
    input wire logic [1:0] I_WITHIN_90PCT,
    input wire logic [1:0] I_ABOVE_21V,
    input wire logic [1:0] I_BELOW_19V95,
    input wire logic [1:0] I_TONE_PRESENT,
    // shared conditions
    input wire logic I_OVERTEMP,
    input wire logic I_UNDERVOLT,
    // controls to the regulator
    output logic [1:0] O_OUTPUT_ON,
    output logic [1:0] O_OCP_TIMER_ON,
    output logic [1:0] O_CABLE_TEST,
    // status snapshot
    output logic [7:0] O_STATUS_ONE,
    output logic [7:0] O_STATUS_TWO
);

    // ------------------------------------------------------------------
    // link side, rising edge: reset sync, data sampling, read event
    // ------------------------------------------------------------------
    dofs_pkg::dofs_rise_t r;
    dofs_pkg::dofs_rise_t next_r;
    dofs_pkg::dofs_fall_t f;
    dofs_pkg::dofs_fall_t next_f;
    dofs_pkg::dofs_sys_t s;
    dofs_pkg::dofs_sys_t next_s;

    always_comb begin
        next_r = r;
        next_r.rst_meta = I_RESET;
        next_r.rst = r.rst_meta;
        // data is stable around the rise by protocol, no resync needed
        next_r.sda_rise = I_SDA;
        next_r.rx = {r.rx[`DOFS_BYTE_W-2:0], I_SDA};
        // ninth rise of a read byte: status update event
        if (f.st == dofs_pkg::DOFS_RACK) begin
            next_r.rd_tgl = ~r.rd_tgl;
        end
        if (r.rst) begin
            next_r.sda_rise = 1'b1;
            next_r.rx = '0;
            next_r.rd_tgl = 1'b0;
        end
    end

    always_ff @(posedge I_SCL) begin
        r <= next_r;
    end

    // ------------------------------------------------------------------
    // link side, falling edge: framing and data drive
    // ------------------------------------------------------------------
    // stop is not visible on the link clock; a finished transfer parks
    // in idle, where the next falling edge with data low is a start
    always_comb begin
        next_f = f;
        case (f.st)
            dofs_pkg::DOFS_IDLE: begin
                next_f.sda_oe = 1'b0;
                if (!I_SDA) begin
                    next_f.st = dofs_pkg::DOFS_ADDR;
                    next_f.cnt = '0;
                    next_f.sel_two = 1'b0;
                end
            end
            dofs_pkg::DOFS_ADDR: begin
                if (f.cnt == `DOFS_BIT_LAST) begin
                    if (r.rx[`DOFS_BYTE_W-1:1] == `DOFS_DEV_ADDR) begin
                        next_f.st = dofs_pkg::DOFS_ADDR_ACK;
                        next_f.is_read = r.rx[`DOFS_RW_BIT];
                        next_f.sda_oe = 1'b1;
                    end else begin
                        next_f.st = dofs_pkg::DOFS_IDLE;
                    end
                end else begin
                    next_f.cnt = f.cnt + 3'h1;
                end
            end
            dofs_pkg::DOFS_ADDR_ACK: begin
                next_f.cnt = '0;
                if (f.is_read) begin
                    next_f.st = dofs_pkg::DOFS_RDATA;
                    next_f.sel_two = 1'b0;
                    next_f.tx = s.stat_one;
                    next_f.sda_oe = ~s.stat_one[`DOFS_BYTE_W-1];
                end else begin
                    next_f.st = dofs_pkg::DOFS_WDATA;
                    next_f.sda_oe = 1'b0;
                end
            end
            dofs_pkg::DOFS_RDATA: begin
                if (f.cnt == `DOFS_BIT_LAST) begin
                    next_f.st = dofs_pkg::DOFS_RACK;
                    next_f.sda_oe = 1'b0;
                end else begin
                    next_f.cnt = f.cnt + 3'h1;
                    next_f.tx = {f.tx[`DOFS_BYTE_W-2:0], 1'b0};
                    next_f.sda_oe = ~f.tx[`DOFS_BYTE_W-2];
                end
            end
            dofs_pkg::DOFS_RACK: begin
                next_f.cnt = '0;
                if (!r.sda_rise) begin
                    // master acknowledged: alternate the register
                    next_f.st = dofs_pkg::DOFS_RDATA;
                    next_f.sel_two = ~f.sel_two;
                    next_f.tx = f.sel_two ? s.stat_one : s.stat_two;
                    next_f.sda_oe = f.sel_two ?
                        ~s.stat_one[`DOFS_BYTE_W-1] :
                        ~s.stat_two[`DOFS_BYTE_W-1];
                end else begin
                    next_f.st = dofs_pkg::DOFS_IDLE;
                end
            end
            dofs_pkg::DOFS_WDATA: begin
                if (f.cnt == `DOFS_BIT_LAST) begin
                    next_f.st = dofs_pkg::DOFS_WACK;
                    next_f.wr_data = r.rx;
                    next_f.sda_oe = 1'b1;
                end else begin
                    next_f.cnt = f.cnt + 3'h1;
                end
            end
            dofs_pkg::DOFS_WACK: begin
                next_f.st = dofs_pkg::DOFS_IDLE;
                next_f.sda_oe = 1'b0;
                next_f.wr_tgl = ~f.wr_tgl;
            end
            default: begin
                next_f.st = dofs_pkg::DOFS_IDLE;
                next_f.sda_oe = 1'b0;
            end
        endcase
        // data falling while the clock was high is a repeated start
        if (f.st != dofs_pkg::DOFS_IDLE && r.sda_rise && !I_SDA) begin
            next_f.st = dofs_pkg::DOFS_ADDR;
            next_f.cnt = '0;
            next_f.sda_oe = 1'b0;
            next_f.sel_two = 1'b0;
        end
        next_f.busy = (next_f.st != dofs_pkg::DOFS_IDLE);
        if (r.rst) begin
            next_f = '0;
            next_f.st = dofs_pkg::DOFS_IDLE;
        end
    end

    always_ff @(negedge I_SCL) begin
        f <= next_f;
    end

    // ------------------------------------------------------------------
    // system side: crossings, controls, fault flags
    // ------------------------------------------------------------------
    logic wr_ev;
    logic rd_ev;
    logic [1:0] oc;
    logic [1:0] b85;
    logic [1:0] w90;
    logic [1:0] a21;
    logic [1:0] b1995;
    logic ot;
    logic uv;
    logic ch;

    always_comb begin
        next_s = s;
        next_s.cond_meta = {I_TONE_PRESENT, I_BELOW_19V95, I_ABOVE_21V,
                            I_WITHIN_90PCT, I_BELOW_85PCT, I_UNDERVOLT,
                            I_OVERTEMP, I_OVERCURRENT};
        next_s.cond = s.cond_meta;
        next_s.wr_sync = {s.wr_sync[1:0], f.wr_tgl};
        next_s.rd_sync = {s.rd_sync[1:0], r.rd_tgl};
        next_s.busy_sync = {s.busy_sync[0], f.busy};
        wr_ev = s.wr_sync[2] ^ s.wr_sync[1];
        rd_ev = s.rd_sync[2] ^ s.rd_sync[1];
        oc = s.cond[`DOFS_C_OC +: 2];
        b85 = s.cond[`DOFS_C_B85 +: 2];
        w90 = s.cond[`DOFS_C_W90 +: 2];
        a21 = s.cond[`DOFS_C_A21 +: 2];
        b1995 = s.cond[`DOFS_C_B1995 +: 2];
        ot = s.cond[`DOFS_C_OTEMP];
        uv = s.cond[`DOFS_C_UVOLT];
        ch = f.wr_data[`DOFS_CTL_CH_BIT];

        // write decode; wr_data has been still since its toggle
        if (wr_ev) begin
            if (!f.wr_data[`DOFS_CTL_REG_BIT]) begin
                next_s.on[ch] = f.wr_data[`DOFS_CTL_ON_BIT];
                next_s.timer_on[ch] = f.wr_data[`DOFS_CTL_TIMER_BIT];
            end else begin
                next_s.cable_test[ch] = f.wr_data[`DOFS_CTL_CABLE_BIT];
            end
        end

        // read event samples latched faults, set still wins below
        if (rd_ev && !ot) begin
            next_s.overtemp = 1'b0;
        end
        if (rd_ev && !uv) begin
            next_s.undervolt = 1'b0;
        end
        if (ot) begin
            next_s.overtemp = 1'b1;
            next_s.on = '0;
        end
        if (uv) begin
            next_s.undervolt = 1'b1;
            next_s.on = '0;
        end

        for (int c = 0; c < 2; c++) begin
            // overcurrent: timed shutdown or live follow
            if (s.timer_on[c]) begin
                if (rd_ev && !oc[c]) begin
                    next_s.ocp[c] = 1'b0;
                end
                if (s.on[c] && oc[c]) begin
                    if (s.oc_cnt[c] ==
                        `DOFS_OCP_CNT_W'(OCP_CYCLES - 1)) begin
                        next_s.ocp[c] = 1'b1;
                        next_s.on[c] = 1'b0;
                        next_s.oc_cnt[c] = '0;
                    end else begin
                        next_s.oc_cnt[c] = s.oc_cnt[c] +
                            `DOFS_OCP_CNT_W'(1);
                    end
                end else begin
                    next_s.oc_cnt[c] = '0;
                end
            end else begin
                next_s.ocp[c] = oc[c];
                next_s.oc_cnt[c] = '0;
            end

            // disabled flag: write that enables clears it, off sets it
            if (wr_ev) begin
                next_s.out_off[c] = ~next_s.on[c];
            end
            if (!next_s.on[c]) begin
                next_s.out_off[c] = 1'b1;
            end

            // power bad with hysteresis, forced while off
            if (!next_s.on[c] || b85[c]) begin
                next_s.power_bad[c] = 1'b1;
            end else if (w90[c]) begin
                next_s.power_bad[c] = 1'b0;
            end

            // cable flag only meaningful during the test
            if (!s.cable_test[c]) begin
                next_s.cable_open[c] = 1'b0;
            end else if (a21[c]) begin
                next_s.cable_open[c] = 1'b1;
            end else if (b1995[c]) begin
                next_s.cable_open[c] = 1'b0;
            end

            next_s.tone[c] = s.cond[`DOFS_C_TONE + c];
        end

        // snapshot frozen during a transfer so the link reads stable words;
        // the trade is that a transfer shows flags as of its start
        if (!s.busy_sync[1]) begin
            next_s.stat_one = {s.undervolt, s.overtemp,
                               s.power_bad, s.ocp, s.out_off};
            next_s.stat_two = {{`DOFS_S2_UNUSED_W{1'b0}},
                               s.tone, s.cable_open};
        end

        if (I_RESET) begin
            next_s = '0;
            next_s.timer_on = '1;
            next_s.out_off = '1;
            next_s.power_bad = '1;
            next_s.stat_one = `DOFS_S1_RST;
            next_s.stat_two = `DOFS_S2_RST;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        s <= next_s;
    end

    // ------------------------------------------------------------------
    // outputs straight from flops, except O_SDA which is tied low
    // ------------------------------------------------------------------
    // the disabled flag drives no interrupt; this block has none at all
    // so a deliberate switch-off never alerts the master
    assign O_SDA = 1'b0;
    assign O_SDA_OE = f.sda_oe;
    assign O_OUTPUT_ON = s.on;
    assign O_OCP_TIMER_ON = s.timer_on;
    assign O_CABLE_TEST = s.cable_test;
    assign O_STATUS_ONE = s.stat_one;
    assign O_STATUS_TWO = s.stat_two;

endmodule : dofs_status

// >>> bench/dofs_status_checker.sv
// concurrent checks on the fault status block's ports
module dofs_status_checker #(
    parameter int unsigned OCP_CYCLES = 20
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    // conditions
    input wire logic [1:0] I_OVERCURRENT,
    input wire logic [1:0] I_BELOW_19V95,
    input wire logic [1:0] I_ABOVE_21V,
    input wire logic I_OVERTEMP,
    input wire logic I_UNDERVOLT,
    // controls and status
    input wire logic [1:0] O_OUTPUT_ON,
    input wire logic [1:0] O_OCP_TIMER_ON,
    input wire logic [1:0] O_CABLE_TEST,
    input wire logic [7:0] O_STATUS_ONE,
    input wire logic [7:0] O_STATUS_TWO
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);
    // ----------------
    // helper counters
    // ----------------
    logic [5:0] off_run;
    logic [31:0] oc_run;
    logic oc_armed;
    assign oc_armed = I_OVERCURRENT[0] && O_OUTPUT_ON[0] && O_OCP_TIMER_ON[0];
    // off_run saturates so a long disabled spell stays visible
    always_ff @(posedge I_SYS_CLK) begin
        off_run <= (I_RESET || O_OUTPUT_ON[0]) ? 6'h00 :
            off_run + {5'h00, off_run != 6'h3f};
        oc_run <= (I_RESET || !oc_armed) ? 32'h0 : oc_run + 32'h1;
    end
    // ----------------
    // assertions
    // ----------------
    sequence s_both_off;
        ##[1:8] (O_OUTPUT_ON == 2'h0);
    endsequence
    a_unused_zero: assert property (O_STATUS_TWO[7:4] == 4'h0)
        else $error("status two unused bits set");
    a_reset_state: assert property ($fell(I_RESET) |->
        O_STATUS_ONE == 8'h33 && O_OUTPUT_ON == 2'h0 &&
        O_OCP_TIMER_ON == 2'h3) else $error("bad state after reset");
    a_otemp_off: assert property ($rose(I_OVERTEMP) |-> s_both_off)
        else $error("overtemperature left an output on");
    a_uvolt_off: assert property ($rose(I_UNDERVOLT) |-> s_both_off)
        else $error("undervoltage left an output on");
    a_off_flags: assert property (off_run == 6'h3f |->
        O_STATUS_ONE[0] && O_STATUS_ONE[4]) else $error("off flags low");
    a_ocp_bound: assert property (oc_run <= OCP_CYCLES + 8)
        else $error("timed overcurrent did not switch off");
    a_cable_set: assert property ($rose(I_ABOVE_21V[0]) &&
        O_CABLE_TEST[0] |-> ##[1:8] O_STATUS_TWO[0])
        else $error("cable open flag not set");
    a_cable_clr: assert property ($rose(I_BELOW_19V95[0]) |->
        ##[1:8] !O_STATUS_TWO[0]) else $error("cable flag not cleared");
    a_test_off: assert property ($fell(O_CABLE_TEST[0]) |->
        ##[1:12] !O_STATUS_TWO[0]) else $error("cable flag outlived test");
endmodule : dofs_status_checker

bind dofs_status dofs_status_checker #(
    .OCP_CYCLES(OCP_CYCLES)
) dofs_status_checker_i (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RESET(I_RESET),
    .I_OVERCURRENT(I_OVERCURRENT),
    .I_BELOW_19V95(I_BELOW_19V95),
    .I_ABOVE_21V(I_ABOVE_21V),
    .I_OVERTEMP(I_OVERTEMP),
    .I_UNDERVOLT(I_UNDERVOLT),
    .O_OUTPUT_ON(O_OUTPUT_ON),
    .O_OCP_TIMER_ON(O_OCP_TIMER_ON),
    .O_CABLE_TEST(O_CABLE_TEST),
    .O_STATUS_ONE(O_STATUS_ONE),
    .O_STATUS_TWO(O_STATUS_TWO)
);

// >>> bench/dofs_master.sv
// serial bus master model facing the status block
module dofs_master (
    // wire level seen by the master
    input wire logic i_sda,
    // clock and pull-down drive
    output logic o_scl,
    output logic o_sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // clock only runs during reset and inside frames
    task automatic run_clk(input int n);
        repeat (n) begin
            #15 o_scl = 1'b0;
            #15 o_scl = 1'b1;
        end
    endtask : run_clk
    // odd offset keeps the link out of step with the system clock
    task automatic start();
        #3 o_sda_low = 1'b1;
        #15;
    endtask : start
    // data moves only while the clock is low, sampled before the fall
    task automatic bit_io(input logic b, output logic r);
        o_scl = 1'b0;
        #7 o_sda_low = !b;
        #8 o_scl = 1'b1;
        #15 r = i_sda;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ak, a);
    endtask : xfer
    task automatic stop();
        o_scl = 1'b0;
        #7 o_sda_low = 1'b1;
        #8 o_scl = 1'b1;
        #7 o_sda_low = 1'b0;
        #8;
    endtask : stop
endmodule : dofs_master

// >>> bench/tb_dofs_status.sv
// self-checking bench for the fault status block
`include "dofs_defines.svh"

module tb_dofs_status;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ot = 1'b0;
    logic uv = 1'b0;
    logic [1:0] oc = 2'h0;
    logic [1:0] b85 = 2'h3;
    logic [1:0] w90 = 2'h0;
    logic [1:0] a21 = 2'h0;
    logic [1:0] b1995 = 2'h3;
    logic [1:0] tone = 2'h0;
    logic [7:0] rd [3];
    logic scl, m_low, sda_oe, sda_val;
    logic [1:0] on, tmr, cab;
    logic [7:0] s1, s2;
    // pulled-up line: low while either party pulls it
    wire sda = !(m_low || (sda_oe && !sda_val));
    int miscompares = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    dofs_status #(
        .OCP_CYCLES(20)
    ) dofs_status_i (
        .I_SYS_CLK(clk), .I_RESET(rst), .I_SCL(scl), .I_SDA(sda),
        .O_SDA(sda_val), .O_SDA_OE(sda_oe), .I_OVERCURRENT(oc),
        .I_BELOW_85PCT(b85), .I_WITHIN_90PCT(w90), .I_ABOVE_21V(a21),
        .I_BELOW_19V95(b1995), .I_TONE_PRESENT(tone),
        .I_OVERTEMP(ot), .I_UNDERVOLT(uv), .O_OUTPUT_ON(on),
        .O_OCP_TIMER_ON(tmr), .O_CABLE_TEST(cab),
        .O_STATUS_ONE(s1), .O_STATUS_TWO(s2)
    );
    dofs_master dofs_master_i (
        .i_sda(sda), .o_scl(scl), .o_sda_low(m_low)
    );
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk
    task automatic bus_read(input int n);
        logic a;
        dofs_master_i.start();
        dofs_master_i.xfer({`DOFS_DEV_ADDR, 1'b1}, 1'b1, rd[0], a);
        check("read address ack", 8'h00, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            dofs_master_i.xfer(8'hff, i == n - 1, rd[i], a);
        end
        dofs_master_i.stop();
        wait_clk(12);
    endtask : bus_read
    task automatic bus_write(input logic [7:0] d);
        logic [7:0] q;
        logic a;
        dofs_master_i.start();
        dofs_master_i.xfer({`DOFS_DEV_ADDR, 1'b0}, 1'b1, q, a);
        check("write address ack", 8'h00, {7'h00, a});
        dofs_master_i.xfer(d, 1'b1, q, a);
        check("data ack", 8'h00, {7'h00, a});
        dofs_master_i.stop();
        wait_clk(12);
    endtask : bus_write
    task automatic t_alternate();
        tone = 2'h1;
        wait_clk(8);
        bus_read(2);
        check("first byte", 8'h33, rd[0]);
        check("second byte", 8'h04, rd[1]);
        bus_read(3);
        check("restart byte", 8'h33, rd[0]);
        check("middle byte", 8'h04, rd[1]);
        check("third byte", 8'h33, rd[2]);
        tone = 2'h0;
    endtask : t_alternate
    task automatic t_enable();
        bus_write(8'h30);
        bus_write(8'h70);
        b85 = 2'h0;
        w90 = 2'h3;
        wait_clk(8);
        check("outputs on", 8'h03, {6'h00, on});
        check("timers on", 8'h03, {6'h00, tmr});
        bus_read(2);
        check("status one clean", 8'h00, rd[0]);
        check("status two clean", 8'h00, rd[1]);
    endtask : t_enable
    task automatic t_pbad();
        b85 = 2'h1;
        w90 = 2'h2;
        wait_clk(8);
        check("power bad set", 8'h10, s1);
        b85 = 2'h0;
        wait_clk(8);
        check("power bad held", 8'h10, s1);
        w90 = 2'h3;
        wait_clk(8);
        check("power bad clear", 8'h00, s1);
    endtask : t_pbad
    task automatic t_ocp_timer();
        oc = 2'h1;
        wait_clk(40);
        check("channel one tripped", 8'h02, {6'h00, on});
        check("trip flags", 8'h15, s1);
        oc = 2'h0;
        wait_clk(8);
        bus_read(1);
        check("trip latched", 8'h15, rd[0]);
        check("trip cleared", 8'h11, s1);
        bus_write(8'h30);
        check("channel one back", 8'h00, s1);
    endtask : t_ocp_timer
    task automatic t_ocp_live();
        bus_write(8'h60);
        check("timer two off", 8'h01, {6'h00, tmr});
        oc = 2'h2;
        wait_clk(40);
        check("limit runs on", 8'h03, {6'h00, on});
        check("live flag", 8'h08, s1);
        oc = 2'h0;
        wait_clk(8);
        check("live flag gone", 8'h00, s1);
        bus_write(8'h70);
    endtask : t_ocp_live
    task automatic t_otemp();
        ot = 1'b1;
        wait_clk(8);
        check("both off", 8'h00, {6'h00, on});
        bus_read(1);
        check("still hot", 8'h73, s1);
        ot = 1'b0;
        wait_clk(8);
        check("hot latched", 8'h73, s1);
        bus_read(1);
        check("hot cleared", 8'h33, s1);
        bus_write(8'h30);
        bus_write(8'h70);
        check("restarted", 8'h00, s1);
    endtask : t_otemp
    task automatic t_uvolt();
        uv = 1'b1;
        wait_clk(8);
        uv = 1'b0;
        wait_clk(8);
        bus_read(1);
        check("undervolt read", 8'hb3, rd[0]);
        check("undervolt cleared", 8'h33, s1);
        check("still off", 8'h00, {6'h00, on});
        bus_write(8'h30);
        bus_write(8'h70);
        check("on again", 8'h03, {6'h00, on});
    endtask : t_uvolt
    task automatic t_cable();
        bus_write(8'h84);
        check("test on", 8'h01, {6'h00, cab});
        a21 = 2'h1;
        b1995 = 2'h2;
        wait_clk(8);
        check("open set", 8'h01, s2);
        a21 = 2'h0;
        wait_clk(8);
        check("open held", 8'h01, s2);
        b1995 = 2'h3;
        wait_clk(8);
        check("open clear", 8'h00, s2);
        a21 = 2'h1;
        b1995 = 2'h2;
        wait_clk(8);
        bus_write(8'h80);
        check("test off clears", 8'h00, s2);
        a21 = 2'h0;
        b1995 = 2'h3;
    endtask : t_cable
    task automatic wrap_up();
        $display("checked %0d wrong %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #300us;
        miscompares++;
        wrap_up();
    end
    initial begin
        // the link side needs clock edges to see the reset, and two more
        // rises after release before its synchroniser lets go
        fork
            dofs_master_i.run_clk(9);
        join_none
        wait_clk(20);
        rst = 1'b0;
        wait_clk(10);
        t_alternate();
        t_enable();
        t_pbad();
        t_ocp_timer();
        t_ocp_live();
        t_otemp();
        t_uvolt();
        t_cable();
        wrap_up();
    end
endmodule : tb_dofs_status
